// [watchdog_timer_keyed.sv]
// keyed watchdog timer with axi4-lite register access
// assumes a 50 MHz aclk, a synchronous sub_clk level and one-cycle core pulses
`timescale 1ns/1ps
module watchdog_timer_keyed
  import wdt_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output wire logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output wire logic        s_axi_wready,
  output wire logic [1:0]  s_axi_bresp,
  output wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output wire logic        s_axi_arready,
  output wire logic [31:0] s_axi_rdata,
  output wire logic [1:0]  s_axi_rresp,
  output wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sub_clk,
  input  wire logic        watchdog_clear_instruction,
  input  wire logic        halt_instruction,
  input  wire logic        lowpower_mode,
  output wire logic        device_reset,
  output wire logic        pc_sp_reset,
  output wire logic        idle_sysclk_keep,
  output wire logic        irq
);

  // ==========================================================================
  // state
  // ==========================================================================
  logic             awready_q;
  logic             wready_q;
  logic             bvalid_q;
  logic [1:0]       bresp_q;
  logic             arready_q;
  logic             rvalid_q;
  logic [1:0]       rresp_q;
  logic [31:0]      rdata_q;
  logic [31:0]      awaddr_q;
  logic [31:0]      wdata_q;
  logic [3:0]       wstrb_q;
  logic [7:0]       ctrl_q;
  logic             key_flag_q;
  logic             idle_keep_q;
  logic             timeout_flag_q;
  logic             powerdown_flag_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_stat_d;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_event;
  logic             irq_q;
  logic             device_reset_q;
  logic             pc_sp_reset_q;
  logic [1:0]       edge_cnt_q;
  key_state_t       st_q;
  logic             do_write;
  logic [2:0]       wr_sel;
  logic             wr_lane0;
  logic             key_fire;
  logic             ovf_normal;
  logic             ovf_lowpower;

  wdt_count_if cif ();

  wdt_sub_counter u_counter (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sub_clk (sub_clk),
    .cif     (cif)
  );

  function automatic logic [2:0] reg_decode(input logic [31:0] addr);
    logic [31:0] a;
    a = {20'h0_0000, addr[11:0] & ADDR_DECODE_MASK};
    if (addr[31:12] != 20'h0_0000) begin
      reg_decode = SEL_NONE;
    end else if (a == OFS_WATCHDOG_CONTROL) begin
      reg_decode = SEL_CTRL;
    end else if (a == OFS_SYSTEM_RESET_FLAGS) begin
      reg_decode = SEL_FLAGS;
    end else if (a == OFS_WDT_STATUS) begin
      reg_decode = SEL_STATUS;
    end else if (a == OFS_IRQ_STATUS) begin
      reg_decode = SEL_ISTAT;
    end else if (a == OFS_IRQ_MASK) begin
      reg_decode = SEL_IMASK;
    end else begin
      reg_decode = SEL_NONE;
    end
  endfunction : reg_decode

  function automatic logic key_valid(input logic [4:0] key);
    key_valid = (key == KEY_ENABLE_A) || (key == KEY_ENABLE_B);
  endfunction : key_valid

  // ==========================================================================
  // axi4-lite write channel
  // ==========================================================================
  assign do_write = !awready_q && !wready_q && !bvalid_q;
  assign wr_sel   = reg_decode(awaddr_q);
  assign wr_lane0 = do_write && wstrb_q[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        awready_q <= 1'b0;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q) begin
        wready_q <= 1'b0;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q  <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // axi4-lite read channel
  // ==========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= '0;
    end else begin
      if (s_axi_arvalid && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rresp_q   <= RESP_OKAY;
        rdata_q   <= '0;
        case (reg_decode(s_axi_araddr))
          SEL_CTRL:   rdata_q[7:0] <= ctrl_q;
          SEL_FLAGS:  rdata_q[7:0] <= {idle_keep_q, 6'h00, key_flag_q};
          SEL_STATUS: rdata_q[1:0] <= {powerdown_flag_q, timeout_flag_q};
          SEL_ISTAT:  rdata_q[IRQ_W-1:0] <= irq_stat_q;
          SEL_IMASK:  rdata_q[IRQ_W-1:0] <= irq_mask_q;
          default:    rresp_q <= RESP_SLVERR;
        endcase
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // key check and key-reset sequence
  // ==========================================================================
  assign key_fire = (st_q == ST_KEYRST);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q       <= ST_RUN;
      edge_cnt_q <= '0;
    end else begin
      case (st_q)
        ST_RUN: begin
          edge_cnt_q <= '0;
          if (!key_valid(ctrl_q[KEY_MSB:KEY_LSB])) begin
            st_q <= ST_KEYWAIT;
          end
        end
        ST_KEYWAIT: begin
          if (cif.tick) begin
            edge_cnt_q <= edge_cnt_q + 2'h1;
            if (edge_cnt_q == KEY_RESET_EDGES - 2'h1) begin
              st_q <= ST_KEYRST;
            end
          end
        end
        ST_KEYRST: begin
          st_q <= ST_RUN;
        end
        default: begin
          st_q <= ST_RUN;
        end
      endcase
    end
  end

  // ==========================================================================
  // control register
  // ==========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (key_fire) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_lane0 && wr_sel == SEL_CTRL) begin
      ctrl_q <= wdata_q[7:0];
    end
  end

  // counter is held clear while a bad key is pending
  assign cif.run   = (st_q == ST_RUN) && key_valid(ctrl_q[KEY_MSB:KEY_LSB]);
  assign cif.clear = watchdog_clear_instruction || halt_instruction;
  assign cif.sel   = ctrl_q[TSEL_MSB:TSEL_LSB];

  // ==========================================================================
  // reset flags and status
  // ==========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_flag_q  <= 1'b0;
      idle_keep_q <= 1'b0;
    end else begin
      if (key_fire) begin
        key_flag_q <= 1'b1;
      end else if (wr_lane0 && wr_sel == SEL_FLAGS && !wdata_q[FLAG_KEY_RESET]) begin
        key_flag_q <= 1'b0;
      end
      if (wr_lane0 && wr_sel == SEL_FLAGS) begin
        idle_keep_q <= wdata_q[FLAG_IDLE_KEEP];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timeout_flag_q   <= 1'b0;
      powerdown_flag_q <= 1'b0;
    end else begin
      if (cif.ovf) begin
        timeout_flag_q <= 1'b1;
      end else if (halt_instruction || watchdog_clear_instruction) begin
        timeout_flag_q <= 1'b0;
      end
      if (halt_instruction) begin
        powerdown_flag_q <= 1'b1;
      end else if (watchdog_clear_instruction) begin
        powerdown_flag_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // reset outputs
  // ==========================================================================
  assign ovf_normal   = cif.ovf && !lowpower_mode;
  assign ovf_lowpower = cif.ovf && lowpower_mode;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      device_reset_q <= 1'b0;
      pc_sp_reset_q  <= 1'b0;
    end else begin
      device_reset_q <= ovf_normal || key_fire;
      pc_sp_reset_q  <= ovf_lowpower;
    end
  end

  // ==========================================================================
  // interrupt status and mask
  // ==========================================================================
  assign irq_event = {halt_instruction, key_fire, cif.ovf};

  always_comb begin
    irq_stat_d = irq_stat_q;
    if (wr_lane0 && wr_sel == SEL_ISTAT) begin
      irq_stat_d = irq_stat_d & ~wdata_q[IRQ_W-1:0];
    end
    irq_stat_d = irq_stat_d | irq_event;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= '0;
      irq_mask_q <= IRQ_MASK_RESET;
      irq_q      <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      if (wr_lane0 && wr_sel == SEL_IMASK) begin
        irq_mask_q <= wdata_q[IRQ_W-1:0];
      end
      irq_q <= |(irq_stat_d & irq_mask_q);
    end
  end

  assign s_axi_awready    = awready_q;
  assign s_axi_wready     = wready_q;
  assign s_axi_bvalid     = bvalid_q;
  assign s_axi_bresp      = bresp_q;
  assign s_axi_arready    = arready_q;
  assign s_axi_rvalid     = rvalid_q;
  assign s_axi_rresp      = rresp_q;
  assign s_axi_rdata      = rdata_q;
  assign device_reset     = device_reset_q;
  assign pc_sp_reset      = pc_sp_reset_q;
  assign idle_sysclk_keep = idle_keep_q;
  assign irq              = irq_q;

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_valid_key_quiet;
    st_q == ST_RUN && key_valid(ctrl_q[KEY_MSB:KEY_LSB]) |=> st_q == ST_RUN && !key_fire;
  endproperty
  a_valid_key_quiet: assert property (p_valid_key_quiet) else $error("reset on valid key");

  property p_key_fire;
    key_fire |=> device_reset_q && key_flag_q && ctrl_q == CTRL_RESET;
  endproperty
  a_key_fire: assert property (p_key_fire) else $error("key reset effects missing");

  property p_key_delay;
    st_q == ST_KEYWAIT && cif.tick && edge_cnt_q == KEY_RESET_EDGES - 2'h1 |=> key_fire;
  endproperty
  a_key_delay: assert property (p_key_delay) else $error("key reset not on third edge");

  property p_key_flag_hold;
    key_flag_q && !(wr_lane0 && wr_sel == SEL_FLAGS) |=> key_flag_q;
  endproperty
  a_key_flag_hold: assert property (p_key_flag_hold) else $error("key flag lost");

  property p_normal_ovf;
    ovf_normal |=> device_reset_q && timeout_flag_q && !pc_sp_reset_q;
  endproperty
  a_normal_ovf: assert property (p_normal_ovf) else $error("normal overflow wrong");

  property p_lowpower_ovf;
    ovf_lowpower |=> pc_sp_reset_q && timeout_flag_q && !device_reset_q;
  endproperty
  a_lowpower_ovf: assert property (p_lowpower_ovf) else $error("low-power overflow wrong");

  property p_ctrl_reset;
    $rose(aresetn) |-> ctrl_q == CTRL_RESET;
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset) else $error("control reset value wrong");

  property p_halt;
    halt_instruction && !cif.ovf |=> powerdown_flag_q && !timeout_flag_q;
  endproperty
  a_halt: assert property (p_halt) else $error("halt flags wrong");

  property p_ovf_restart;
    cif.ovf |=> !cif.ovf [*8];
  endproperty
  a_ovf_restart: assert property (p_ovf_restart) else $error("overflow repeated");

endmodule : watchdog_timer_keyed

// [wdt_pkg.sv]
// constants for the keyed watchdog: register map, field layout, reset values, timing
// assumes a 32-bit axi4-lite register bus and a 50 MHz system clock
package wdt_pkg;

  // ==========================================================================
  // register map (byte addresses)
  // ==========================================================================
  localparam logic [31:0] OFS_WATCHDOG_CONTROL    = 32'h0000_0000;
  localparam logic [31:0] OFS_SYSTEM_RESET_FLAGS  = 32'h0000_0004;
  localparam logic [31:0] OFS_WDT_STATUS          = 32'h0000_0008;
  localparam logic [31:0] OFS_IRQ_STATUS          = 32'h0000_000C;
  localparam logic [31:0] OFS_IRQ_MASK            = 32'h0000_0010;
  localparam logic [11:0] ADDR_DECODE_MASK        = 12'h0FFC;

  // decoded register selects
  localparam logic [2:0]  SEL_NONE   = 3'h0;
  localparam logic [2:0]  SEL_CTRL   = 3'h1;
  localparam logic [2:0]  SEL_FLAGS  = 3'h2;
  localparam logic [2:0]  SEL_STATUS = 3'h3;
  localparam logic [2:0]  SEL_ISTAT  = 3'h4;
  localparam logic [2:0]  SEL_IMASK  = 3'h5;

  // ==========================================================================
  // field layout and reset values
  // ==========================================================================
  localparam int          KEY_MSB          = 7;
  localparam int          KEY_LSB          = 3;
  localparam int          TSEL_MSB         = 2;
  localparam int          TSEL_LSB         = 0;
  localparam logic [7:0]  CTRL_RESET       = 8'h53;
  localparam logic [4:0]  KEY_ENABLE_A     = 5'h15;
  localparam logic [4:0]  KEY_ENABLE_B     = 5'h0A;
  localparam int          FLAG_IDLE_KEEP   = 7;
  localparam int          FLAG_KEY_RESET   = 0;
  localparam int          STAT_TIMEOUT     = 0;
  localparam int          STAT_POWERDOWN   = 1;
  localparam int          IRQ_W            = 3;
  localparam int          IRQ_TIMEOUT      = 0;
  localparam int          IRQ_KEY_RESET    = 1;
  localparam int          IRQ_HALT         = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int          CNT_W            = 18;
  // exponent of the timeout for each select code
  localparam int          SEL_EXP [8]      = '{8, 10, 12, 14, 15, 16, 17, 18};
  // third subsidiary edge after a bad key lands 2 to 3 periods later
  localparam logic [1:0]  KEY_RESET_EDGES  = 2'h3;

  typedef enum logic [2:0] {
    ST_RUN     = 3'b001,
    ST_KEYWAIT = 3'b010,
    ST_KEYRST  = 3'b100
  } key_state_t;

endpackage : wdt_pkg

// [wdt_count_if.sv]
// signals between the watchdog control logic and its subsidiary-clock counter
// assumes both ends sit on the same system clock
`timescale 1ns/1ps
interface wdt_count_if;
  import wdt_pkg::*;
  logic       tick;
  logic       clear;
  logic       run;
  logic [2:0] sel;
  logic       ovf;
  modport ctl     (input tick, input ovf, output clear, output run, output sel);
  modport counter (output tick, output ovf, input clear, input run, input sel);
endinterface : wdt_count_if

// [wdt_sub_counter.sv]
// subsidiary clock edge detector and watchdog divider counter
// assumes sub_clk is a slow level sampled synchronously by aclk
`timescale 1ns/1ps
module wdt_sub_counter
  import wdt_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        sub_clk,
  wdt_count_if.counter     cif
);

  logic             sub_q;
  logic [CNT_W-1:0] cnt_q;

  function automatic logic [CNT_W-1:0] limit_of(input logic [2:0] sel);
    limit_of = CNT_W'((32'd1 << SEL_EXP[sel]) - 32'd1);
  endfunction : limit_of

  // ==========================================================================
  // subsidiary clock rising edge
  // ==========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sub_q    <= sub_clk;
      cif.tick <= 1'b0;
    end else begin
      sub_q    <= sub_clk;
      cif.tick <= sub_clk & ~sub_q;
    end
  end

  // ==========================================================================
  // divider counter
  // ==========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q   <= '0;
      cif.ovf <= 1'b0;
    end else begin
      cif.ovf <= 1'b0;
      if (cif.clear || !cif.run) begin
        cnt_q <= '0;
      end else if (cif.tick) begin
        if (cnt_q == limit_of(cif.sel)) begin
          cnt_q   <= '0;
          cif.ovf <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_sel_limit;
    cif.ovf |-> $past(cnt_q) == limit_of($past(cif.sel)) && cnt_q == '0;
  endproperty
  a_sel_limit: assert property (p_sel_limit) else $error("overflow at wrong count");

  property p_clear_zero;
    cif.clear |=> cnt_q == '0 && !cif.ovf;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("clear did not zero counter");

  property p_sub_edge;
    !sub_q && sub_clk |=> cif.tick;
  endproperty
  a_sub_edge: assert property (p_sub_edge) else $error("subsidiary edge missed");

endmodule : wdt_sub_counter

// [wdt_core_model.sv]
// core model: clear-instruction and halt strobes, sleep level
// assumes the shared aclk; any watchdog reset wakes the core
`timescale 1ns/1ps
module wdt_core_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic device_reset,
  input  wire logic pc_sp_reset,
  output logic      clear_strobe,
  output logic      halt_strobe,
  output logic      sleep_level
);
  // ==========================================================================
  // strobes and sleep level
  initial begin
    clear_strobe = 1'h0;
    halt_strobe  = 1'h0;
    sleep_level  = 1'h0;
  end
  always @(posedge aclk) begin
    if (!aresetn || device_reset || pc_sp_reset) begin
      sleep_level <= 1'h0;
    end
  end
  task automatic clear_wdt();
    @(posedge aclk);
    clear_strobe <= 1'h1;
    @(posedge aclk);
    clear_strobe <= 1'h0;
  endtask : clear_wdt
  task automatic halt_core();
    @(posedge aclk);
    halt_strobe <= 1'h1;
    sleep_level <= 1'h1;
    @(posedge aclk);
    halt_strobe <= 1'h0;
  endtask : halt_core
endmodule : wdt_core_model

// [watchdog_timer_keyed_bench.sv]
// bench for the keyed watchdog: axi4-lite tasks, core model, sub clock
// assumes sub_clk at a quarter of aclk and the answer timing of the hand-over
`timescale 1ns/1ps
module watchdog_timer_keyed_bench;
  import wdt_pkg::*;
  // ==========================================================================
  // signals and instances
  logic        aclk, aresetn, sub_clk;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        clr, hlt, slp, device_reset, pc_sp_reset, keep, irq;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          n_dev = 0;
  int          n_pcs = 0;
  int          t, d, e;
  watchdog_timer_keyed dut (
    .aclk, .aresetn, .sub_clk, .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .watchdog_clear_instruction(clr),
    .halt_instruction(hlt), .lowpower_mode(slp), .device_reset, .pc_sp_reset,
    .idle_sysclk_keep(keep), .irq
  );
  wdt_core_model core (
    .aclk, .aresetn, .device_reset, .pc_sp_reset, .clear_strobe(clr),
    .halt_strobe(hlt), .sleep_level(slp)
  );
  initial begin
    aclk = 1'h0;
    forever #10 aclk = ~aclk;
  end
  initial begin
    sub_clk = 1'h0;
    forever begin
      repeat (2) @(posedge aclk);
      sub_clk <= ~sub_clk;
    end
  end
  always @(negedge aclk) begin
    cyc <= cyc + 1;
    n_dev <= n_dev + (device_reset === 1'h1);
    n_pcs <= n_pcs + (pc_sp_reset === 1'h1);
  end
  // ==========================================================================
  // tasks
  task automatic results();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  task automatic chk(input string what, input logic [31:0] x, input logic [31:0] y);
    n_compared++;
    if (y !== x) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, x, y);
    end
  endtask : chk
  task automatic hang(input string what);
    error_cnt++;
    $display("CHECK FAILED %s expected answer seen none", what);
    results();
  endtask : hang
  function automatic logic [31:0] w8(input logic [7:0] v);
    return {24'h00_0000, v};
  endfunction : w8
  task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] er);
    bit pa = 1'h1, pw = 1'h1, pb = 1'h1, ta, tw, tb;
    logic [1:0] r;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int i = 0; pb; i++) begin
      if (i > 50) hang("write");
      @(negedge aclk);
      ta = pa && awready === 1'h1;
      tw = pw && wready === 1'h1;
      tb = bvalid === 1'h1;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      if (tb) bready <= 1'h0;
      pa = pa && !ta;
      pw = pw && !tw;
      pb = !tb;
    end
    chk($sformatf("bresp %h", a), w8(er), w8(r));
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] x, input logic [1:0] er);
    bit pa = 1'h1, pb = 1'h1, ta, tb;
    logic [31:0] v;
    logic [1:0] r;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int i = 0; pb; i++) begin
      if (i > 50) hang("read");
      @(negedge aclk);
      ta = pa && arready === 1'h1;
      tb = rvalid === 1'h1;
      v = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'h0;
      if (tb) rready <= 1'h0;
      pa = pa && !ta;
      pb = !tb;
    end
    chk($sformatf("rdata %h", a), x, v);
    chk($sformatf("rresp %h", a), w8(er), w8(r));
  endtask : rd
  task automatic pulse(input bit pcs, input int bound);
    int s0;
    s0 = pcs ? n_pcs : n_dev;
    t = cyc;
    for (int i = 0; s0 == (pcs ? n_pcs : n_dev); i++) begin
      if (i > bound) hang("reset pulse");
      @(negedge aclk);
    end
    t = cyc - t;
  endtask : pulse
  task automatic irq_is(input logic v);
    repeat (3) @(negedge aclk);
    chk("irq", w8(v), w8(irq));
  endtask : irq_is
  // ==========================================================================
  // main sequence
  initial begin
    aresetn = 1'h0;
    awaddr = 32'h0000_0000;
    wdata = 32'h0000_0000;
    araddr = 32'h0000_0000;
    awvalid = 1'h0;
    wvalid = 1'h0;
    bready = 1'h0;
    arvalid = 1'h0;
    rready = 1'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    rd(OFS_WATCHDOG_CONTROL, w8(CTRL_RESET), RESP_OKAY);
    rd(OFS_SYSTEM_RESET_FLAGS, 0, RESP_OKAY);
    rd(OFS_WDT_STATUS, 0, RESP_OKAY);
    rd(OFS_IRQ_MASK, 0, RESP_OKAY);
    rd(32'h0000_0040, 0, RESP_SLVERR);
    wr(32'h0000_0040, 32'h0000_00ff, RESP_SLVERR);
    for (int s = 0; s < 8; s++) begin
      wr(OFS_WATCHDOG_CONTROL, w8({KEY_ENABLE_A, s[2:0]}), RESP_OKAY);
      rd(OFS_WATCHDOG_CONTROL, w8({KEY_ENABLE_A, s[2:0]}), RESP_OKAY);
    end
    chk("resets with valid key", 0, n_dev);
    wr(OFS_WATCHDOG_CONTROL, w8({KEY_ENABLE_B, 3'h0}), RESP_OKAY);
    d = n_dev;
    repeat (4) begin
      core.clear_wdt();
      repeat (700) @(posedge aclk);
    end
    chk("resets while cleared", d, n_dev);
    for (int s = 0; s < 2; s++) begin
      wr(OFS_WATCHDOG_CONTROL, w8({KEY_ENABLE_B, s[2:0]}), RESP_OKAY);
      core.clear_wdt();
      e = 4 << SEL_EXP[s];
      pulse(0, e + 40);
      chk("overflow time", 1, t > e - 6 && t < e + 10);
      rd(OFS_WDT_STATUS, 1, RESP_OKAY);
    end
    wr(OFS_WATCHDOG_CONTROL, w8({KEY_ENABLE_B, 3'h0}), RESP_OKAY);
    wr(OFS_IRQ_STATUS, 7, RESP_OKAY);
    wr(OFS_IRQ_MASK, 4, RESP_OKAY);
    d = n_dev;
    core.halt_core();
    rd(OFS_WDT_STATUS, 2, RESP_OKAY);
    rd(OFS_IRQ_STATUS, 4, RESP_OKAY);
    irq_is(1'h1);
    pulse(1, 1100);
    chk("sleep overflow time", 1, t > 980 && t < 1040);
    chk("full reset in sleep", d, n_dev);
    rd(OFS_WDT_STATUS, 3, RESP_OKAY);
    wr(OFS_IRQ_STATUS, 7, RESP_OKAY);
    irq_is(1'h0);
    wr(OFS_SYSTEM_RESET_FLAGS, 32'h0000_0080, RESP_OKAY);
    chk("idle keep", 1, keep);
    core.clear_wdt();
    wr(OFS_WATCHDOG_CONTROL, 32'h0000_0003, RESP_OKAY);
    pulse(0, 40);
    chk("key reset time", 1, t >= 4 && t <= 16);
    rd(OFS_SYSTEM_RESET_FLAGS, 32'h0000_0081, RESP_OKAY);
    rd(OFS_WATCHDOG_CONTROL, w8(CTRL_RESET), RESP_OKAY);
    rd(OFS_IRQ_STATUS, 2, RESP_OKAY);
    irq_is(1'h0);
    wr(OFS_IRQ_MASK, 2, RESP_OKAY);
    irq_is(1'h1);
    wr(OFS_IRQ_STATUS, 2, RESP_OKAY);
    irq_is(1'h0);
    wr(OFS_SYSTEM_RESET_FLAGS, 32'h0000_0081, RESP_OKAY);
    rd(OFS_SYSTEM_RESET_FLAGS, 32'h0000_0081, RESP_OKAY);
    wr(OFS_SYSTEM_RESET_FLAGS, 32'h0000_0080, RESP_OKAY);
    rd(OFS_SYSTEM_RESET_FLAGS, 32'h0000_0080, RESP_OKAY);
    results();
  end
endmodule : watchdog_timer_keyed_bench
